// ---- src/slp_defs.svh ----
// Purpose: Offsets, field positions, reset values and fixed readbacks of the link parameter bank
// Assumes: Included by the bank module only; the package does not include it
// Notes: Definitions only
`ifndef SLP_DEFS_SVH
`define SLP_DEFS_SVH

// ==========================================================
// Register offsets
`define SLP_OFF_FRAMES      8'h70
`define SLP_OFF_CONV        8'h71
`define SLP_OFF_RES_CTRL    8'h72
`define SLP_OFF_NPRIME      8'h73
`define SLP_OFF_SAMPLES     8'h74
`define SLP_OFF_DENSITY_AND_CONTROL_WORDS       8'h75
`define SLP_OFF_USER1       8'h76
`define SLP_OFF_USER2       8'h77
`define SLP_OFF_CHK0        8'h78
`define SLP_OFF_CHK1        8'h79

// ==========================================================
// Field positions
`define SLP_FRAMES_MSB      4
`define SLP_CONV_BIT        0
`define SLP_CS_MSB          7
`define SLP_CS_LSB          6
`define SLP_RES_MSB         4
`define SLP_HD_BIT          7
`define SLP_CHKDIS_BIT      7
`define SLP_LANES           2

// ==========================================================
// Reset values
`define SLP_RST_FRAMES      5'h00
`define SLP_RST_CONV        1'h0
`define SLP_RST_CS          2'h0
`define SLP_RST_USER        8'h00
`define SLP_RST_BYTE        8'h00

// ==========================================================
// Fixed readbacks
`define SLP_RO_RES          5'h0d
`define SLP_RO_NPRIME       5'h0f
`define SLP_RO_SAMPLES      5'h00
`define SLP_RO_HD           1'h0
`define SLP_RO_CF           5'h00

// ==========================================================
// Octets per frame for one and two converters on one lane
`define SLP_OCTETS_ONE      8'h02
`define SLP_OCTETS_TWO      8'h04

`endif

// ---- src/slp_pkg.sv ----
// Purpose: Types shared by the link parameter bank and its users
// Assumes: Field widths are written as literals; slp_defs.svh is not included here
// Notes: Nothing is imported; users write slp_pkg::name
package slp_pkg;

  // ==========================================================
  // Register access request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } slp_req_t;

  // ==========================================================
  // Parameters handed to the serial link
  typedef struct packed {
    logic [4:0] frames;
    logic two_conv;
    logic [1:0] ctrl_bits;
    logic [4:0] res_m1;
    logic [4:0] nprime_m1;
    logic [4:0] samples_m1;
    logic hd;
    logic [4:0] cf;
    logic [7:0] octets;
  } slp_link_cfg_t;

  // ==========================================================
  // Link identity and lane parameters from neighbouring registers
  typedef struct packed {
    logic [7:0] dev_id;
    logic [3:0] bank_id;
    logic [4:0] lane0_id;
    logic [4:0] lane1_id;
    logic scramble;
    logic two_lanes;
    logic chk_disable;
  } slp_ident_t;

endpackage

// ---- src/slp_param_regs.sv ----
// Purpose: Link framing parameter registers with automatic per-lane checksums
// Assumes: Register port is on SYS_CLK_IN; identity inputs come from same-clock registers
// Notes: Read data appears one cycle after the read strobe
`timescale 1ns/1ps
`include "slp_defs.svh"

// Contract
// - Frames per multiframe is five writable low bits; upper three reserved.
// - Converter bit 0 means one converter, 1 means both inputs used.
// - Two-bit control-bits field: none, overrange, over/underflow, unused code.
// - Resolution field is read-only and returns thirteen.
// - Total bits per sample is read-only and returns fifteen.
// - Samples per frame is read-only and returns zero.
// - High-density enable is read-only and always zero.
// - Control words per frame is read-only five bits, always zero.
// - Two user bytes are plain read/write storage with no side effect.
// - Lane 0 checksum reads the modulo-256 sum of lane 0 parameters.
// - Lane 1 checksum reads the modulo-256 sum of lane 1 parameters.
// - Octets per frame equals twice converters divided by lanes; the code gives 2 for one converter on two lanes, not 1.
// - Checksum disable bit suppresses the checksum parameter.
module slp_param_regs (
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  input wire slp_pkg::slp_req_t REQ_IN,
  input wire slp_pkg::slp_ident_t IDENT_IN,
  output logic [7:0] RDATA_OUT,
  output slp_pkg::slp_link_cfg_t CFG_OUT,
  output logic CHK_VALID_OUT
);

  // ==========================================================
  // Decode
  logic wr_frames;
  logic wr_conv;
  logic wr_res;
  logic wr_user1;
  logic wr_user2;
  assign wr_frames = REQ_IN.wr && (REQ_IN.addr == `SLP_OFF_FRAMES);
  assign wr_conv = REQ_IN.wr && (REQ_IN.addr == `SLP_OFF_CONV);
  assign wr_res = REQ_IN.wr && (REQ_IN.addr == `SLP_OFF_RES_CTRL);
  assign wr_user1 = REQ_IN.wr && (REQ_IN.addr == `SLP_OFF_USER1);
  assign wr_user2 = REQ_IN.wr && (REQ_IN.addr == `SLP_OFF_USER2);

  // ==========================================================
  // Writable fields
  logic [4:0] frames_q;
  logic conv_q;
  logic [1:0] cs_q;
  logic [7:0] user1_q;
  logic [7:0] user2_q;

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      frames_q <= `SLP_RST_FRAMES;
    end else if (wr_frames) begin
      frames_q <= REQ_IN.wdata[`SLP_FRAMES_MSB:0];
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      conv_q <= `SLP_RST_CONV;
    end else if (wr_conv) begin
      conv_q <= REQ_IN.wdata[`SLP_CONV_BIT];
    end
  end

  // Code 11 is stored as written; the link treats it as unused
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cs_q <= `SLP_RST_CS;
    end else if (wr_res) begin
      cs_q <= REQ_IN.wdata[`SLP_CS_MSB:`SLP_CS_LSB];
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      user1_q <= `SLP_RST_USER;
      user2_q <= `SLP_RST_USER;
    end else begin
      if (wr_user1) begin
        user1_q <= REQ_IN.wdata;
      end
      if (wr_user2) begin
        user2_q <= REQ_IN.wdata;
      end
    end
  end

  // ==========================================================
  // Derived octets per frame
  logic [7:0] octets;
  always_comb begin
    if (conv_q && !IDENT_IN.two_lanes) begin
      octets = `SLP_OCTETS_TWO;
    end else begin
      octets = `SLP_OCTETS_ONE;
    end
  end

  // ==========================================================
  // Checksums: sum of the encoded lane parameters, modulo 256
  logic [7:0] common_sum;
  logic [7:0] sum0;
  logic [7:0] sum1;
  logic [7:0] chk0_q;
  logic [7:0] chk1_q;
  logic chk_valid_q;

  always_comb begin
    common_sum = IDENT_IN.dev_id
      + {4'h0, IDENT_IN.bank_id}
      + {7'h00, IDENT_IN.scramble}
      + {7'h00, IDENT_IN.two_lanes}
      + (octets - 8'h01)
      + {3'h0, frames_q}
      + {7'h00, conv_q}
      + {6'h00, cs_q}
      + {3'h0, `SLP_RO_RES}
      + {3'h0, `SLP_RO_SAMPLES}
      + {7'h00, `SLP_RO_HD}
      + {3'h0, `SLP_RO_NPRIME}
      + {3'h0, `SLP_RO_CF};
  end

  // One checksum per lane; the lanes differ only in their lane identity
  for (genvar ln = 0; ln < `SLP_LANES; ln++) begin : g_lane
    logic [4:0] lane_id;
    logic [7:0] lane_sum;
    logic [7:0] lane_chk_q;
    assign lane_id = (ln == 0) ? IDENT_IN.lane0_id : IDENT_IN.lane1_id;
    assign lane_sum = common_sum + {3'h0, lane_id};

    // Recomputed every cycle so any field change shows one cycle later
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
        lane_chk_q <= `SLP_RST_BYTE;
      end else if (IDENT_IN.chk_disable) begin
        lane_chk_q <= `SLP_RST_BYTE;
      end else begin
        lane_chk_q <= lane_sum;
      end
    end
  end

  assign sum0 = g_lane[0].lane_sum;
  assign sum1 = g_lane[1].lane_sum;
  assign chk0_q = g_lane[0].lane_chk_q;
  assign chk1_q = g_lane[1].lane_chk_q;

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      chk_valid_q <= 1'b0;
    end else begin
      chk_valid_q <= !IDENT_IN.chk_disable;
    end
  end

  // ==========================================================
  // Read mux; reserved and open bits read zero
  logic [7:0] rd_mux;
  always_comb begin
    case (REQ_IN.addr)
      `SLP_OFF_FRAMES: rd_mux = {3'h0, frames_q};
      `SLP_OFF_CONV: rd_mux = {7'h00, conv_q};
      `SLP_OFF_RES_CTRL: rd_mux = {cs_q, 1'b0, `SLP_RO_RES};
      `SLP_OFF_NPRIME: rd_mux = {3'h0, `SLP_RO_NPRIME};
      `SLP_OFF_SAMPLES: rd_mux = {3'h0, `SLP_RO_SAMPLES};
      `SLP_OFF_DENSITY_AND_CONTROL_WORDS: rd_mux = {`SLP_RO_HD, 2'h0, `SLP_RO_CF};
      `SLP_OFF_USER1: rd_mux = user1_q;
      `SLP_OFF_USER2: rd_mux = user2_q;
      `SLP_OFF_CHK0: rd_mux = chk0_q;
      `SLP_OFF_CHK1: rd_mux = chk1_q;
      default: rd_mux = `SLP_RST_BYTE;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      RDATA_OUT <= `SLP_RST_BYTE;
    end else if (REQ_IN.rd) begin
      RDATA_OUT <= rd_mux;
    end
  end

  // ==========================================================
  // Link configuration outputs
  // Changes reach CFG_OUT one cycle after the field register, with no commit step; software is expected to hold the link down meanwhile
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      CFG_OUT <= '0;
    end else begin
      CFG_OUT.frames <= frames_q;
      CFG_OUT.two_conv <= conv_q;
      CFG_OUT.ctrl_bits <= cs_q;
      CFG_OUT.res_m1 <= `SLP_RO_RES;
      CFG_OUT.nprime_m1 <= `SLP_RO_NPRIME;
      CFG_OUT.samples_m1 <= `SLP_RO_SAMPLES;
      CFG_OUT.hd <= `SLP_RO_HD;
      CFG_OUT.cf <= `SLP_RO_CF;
      CFG_OUT.octets <= octets;
    end
  end

  assign CHK_VALID_OUT = chk_valid_q;

  // ==========================================================
  // Assertions
  logic rd_any;
  assign rd_any = REQ_IN.rd;

  // Low through the release edge, so checks skip cycles that still show reset values
  logic live_q;
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      live_q <= 1'b0;
    end else begin
      live_q <= 1'b1;
    end
  end

  a_frames_write: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    wr_frames |=> frames_q == $past(REQ_IN.wdata[`SLP_FRAMES_MSB:0]))
    else $error("frames field did not take written value");

  a_frames_reserved: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    rd_any && REQ_IN.addr == `SLP_OFF_FRAMES |=> RDATA_OUT[7:5] == 3'h0)
    else $error("reserved frames bits read nonzero");

  a_conv_to_link: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    wr_conv |=> ##1 CFG_OUT.two_conv == $past(REQ_IN.wdata[`SLP_CONV_BIT], 2))
    else $error("converter count not passed to link");

  a_cs_write: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    wr_res |=> ##1 CFG_OUT.ctrl_bits == $past(REQ_IN.wdata[`SLP_CS_MSB:`SLP_CS_LSB], 2))
    else $error("control bits not passed to link");

  a_res_readback: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    rd_any && REQ_IN.addr == `SLP_OFF_RES_CTRL |=> RDATA_OUT[5:0] == {1'b0, `SLP_RO_RES})
    else $error("resolution readback wrong");

  a_nprime_readback: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    rd_any && REQ_IN.addr == `SLP_OFF_NPRIME |=> RDATA_OUT == {3'h0, `SLP_RO_NPRIME})
    else $error("total bits readback wrong");

  a_samples_readback: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    rd_any && REQ_IN.addr == `SLP_OFF_SAMPLES |=> RDATA_OUT == {3'h0, `SLP_RO_SAMPLES})
    else $error("samples readback wrong");

  a_density_and_control_words_zero: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    rd_any && REQ_IN.addr == `SLP_OFF_DENSITY_AND_CONTROL_WORDS |=> RDATA_OUT == {`SLP_RO_HD, 2'h0, `SLP_RO_CF})
    else $error("density or control words nonzero");

  a_user_store: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    wr_user1 && !wr_user2 |=> user1_q == $past(REQ_IN.wdata) && $stable(user2_q))
    else $error("user byte storage wrong");

  a_chk0_sum: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    live_q && !IDENT_IN.chk_disable |=> chk0_q == $past(sum0))
    else $error("lane 0 checksum stale");

  a_chk1_lane: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    live_q && !IDENT_IN.chk_disable |=> chk1_q - chk0_q ==
      $past({3'h0, IDENT_IN.lane1_id}) - $past({3'h0, IDENT_IN.lane0_id}))
    else $error("lane 1 checksum inconsistent with lane 0");

  a_octets_rule: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    live_q |=> CFG_OUT.octets == (($past(conv_q) && !$past(IDENT_IN.two_lanes)) ?
      `SLP_OCTETS_TWO : `SLP_OCTETS_ONE))
    else $error("octets per frame wrong");

  a_chk_disable: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    IDENT_IN.chk_disable |=> !CHK_VALID_OUT && chk0_q == 8'h00 && chk1_q == 8'h00)
    else $error("checksum not suppressed");

  a_conv_readback: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    rd_any && REQ_IN.addr == `SLP_OFF_CONV |=> RDATA_OUT == {7'h00, $past(conv_q)})
    else $error("converter bit readback wrong");

  a_cs_readback: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    rd_any && REQ_IN.addr == `SLP_OFF_RES_CTRL |=> RDATA_OUT[7:6] == $past(cs_q))
    else $error("control bits readback wrong");

  a_user2_store: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    wr_user2 |=> user2_q == $past(REQ_IN.wdata) && $stable(user1_q))
    else $error("second user byte storage wrong");

  a_rdata_hold: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    !rd_any |=> $stable(RDATA_OUT))
    else $error("read data changed without a read");

  a_unmapped_zero: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    rd_any && (REQ_IN.addr < `SLP_OFF_FRAMES || REQ_IN.addr > `SLP_OFF_CHK1) |=>
      RDATA_OUT == 8'h00)
    else $error("unmapped offset read nonzero");

  a_chk_valid_live: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    live_q && !IDENT_IN.chk_disable |=> CHK_VALID_OUT)
    else $error("checksum valid low while enabled");

  a_ro_to_link: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    live_q |=> CFG_OUT.res_m1 == `SLP_RO_RES && CFG_OUT.nprime_m1 == `SLP_RO_NPRIME &&
      CFG_OUT.samples_m1 == `SLP_RO_SAMPLES && CFG_OUT.hd == `SLP_RO_HD &&
      CFG_OUT.cf == `SLP_RO_CF)
    else $error("fixed link parameters wrong");

  c_two_conv_one_lane: cover property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    CFG_OUT.octets == `SLP_OCTETS_TWO);
  c_user_write: cover property (@(posedge SYS_CLK_IN) disable iff (RST_IN) wr_user2);
  c_chk_read: cover property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    rd_any && REQ_IN.addr == `SLP_OFF_CHK1 && CHK_VALID_OUT);
  c_chk_off: cover property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    IDENT_IN.chk_disable ##1 !IDENT_IN.chk_disable);
  c_cs_unused: cover property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    wr_res && REQ_IN.wdata[`SLP_CS_MSB:`SLP_CS_LSB] == 2'h3);

endmodule

// ---- dv/test_slp_param_regs.sv ----
// Purpose: Self-checking bench for the link parameter register bank
// Assumes: Same-clock strobe port, read data one cycle after the read edge
// Notes: Random accesses with fixed seed plus corner cases; expectations from a bench model
`timescale 1ns/1ps
module test_slp_param_regs;
  logic SYS_CLK_IN;
  logic RST_IN;
  slp_pkg::slp_req_t REQ_IN;
  slp_pkg::slp_ident_t IDENT_IN;
  logic [7:0] RDATA_OUT;
  slp_pkg::slp_link_cfg_t CFG_OUT;
  logic CHK_VALID_OUT;
  logic [4:0] m_frames;
  logic m_conv;
  logic [1:0] m_cs;
  logic [7:0] m_u1;
  logic [7:0] m_u2;
  logic [7:0] m_rd;
  int n_fail;
  int checks;

  slp_param_regs i_dut (
    .SYS_CLK_IN(SYS_CLK_IN),
    .RST_IN(RST_IN),
    .REQ_IN(REQ_IN),
    .IDENT_IN(IDENT_IN),
    .RDATA_OUT(RDATA_OUT),
    .CFG_OUT(CFG_OUT),
    .CHK_VALID_OUT(CHK_VALID_OUT)
  );

  // ==========================================================
  // Expectations
  function automatic logic [7:0] exp_f();
    return (m_conv && !IDENT_IN.two_lanes) ? 8'h04 : 8'h02;
  endfunction

  function automatic logic [7:0] exp_chk(input logic [4:0] lid);
    logic [7:0] s;
    s = IDENT_IN.dev_id + 8'(IDENT_IN.bank_id) + 8'(lid) + 8'(IDENT_IN.scramble);
    s = s + 8'(IDENT_IN.two_lanes) + exp_f() - 8'h01 + 8'(m_frames) + 8'(m_conv);
    s = s + 8'(m_cs) + 8'h0d + 8'h0f;
    return IDENT_IN.chk_disable ? 8'h00 : s;
  endfunction

  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h70: return {3'h0, m_frames};
      8'h71: return {7'h00, m_conv};
      8'h72: return {m_cs, 1'b0, 5'h0d};
      8'h73: return 8'h0f;
      8'h76: return m_u1;
      8'h77: return m_u2;
      8'h78: return exp_chk(IDENT_IN.lane0_id);
      8'h79: return exp_chk(IDENT_IN.lane1_id);
      default: return 8'h00;
    endcase
  endfunction

  function automatic slp_pkg::slp_link_cfg_t exp_cfg();
    slp_pkg::slp_link_cfg_t c;
    c = '0;
    c.frames = m_frames;
    c.two_conv = m_conv;
    c.ctrl_bits = m_cs;
    c.res_m1 = 5'h0d;
    c.nprime_m1 = 5'h0f;
    c.octets = exp_f();
    return c;
  endfunction

  // ==========================================================
  // Checking and access tasks
  task automatic cmp(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r);
    logic [7:0] e;
    e = exp_rd(a);
    @(posedge SYS_CLK_IN);
    REQ_IN <= '{addr: a, wdata: d, wr: w, rd: r};
    @(posedge SYS_CLK_IN);
    REQ_IN.wr <= 1'b0;
    REQ_IN.rd <= 1'b0;
    if (w) begin
      case (a)
        8'h70: m_frames = d[4:0];
        8'h71: m_conv = d[0];
        8'h72: m_cs = d[7:6];
        8'h76: m_u1 = d;
        8'h77: m_u2 = d;
        default: ;
      endcase
    end
    #1;
    if (r) begin
      cmp(64'(RDATA_OUT), 64'(e));
      m_rd = e;
    end else begin
      cmp(64'(RDATA_OUT), 64'(m_rd));
    end
    @(posedge SYS_CLK_IN);
    #1;
    cmp(64'(CFG_OUT), 64'(exp_cfg()));
    cmp(64'(CHK_VALID_OUT), 64'(!IDENT_IN.chk_disable));
  endtask

  task automatic set_ident(input slp_pkg::slp_ident_t v);
    @(posedge SYS_CLK_IN);
    IDENT_IN <= v;
    @(posedge SYS_CLK_IN);
  endtask

  task automatic do_reset();
    @(posedge SYS_CLK_IN);
    RST_IN <= 1'b1;
    repeat (7) @(posedge SYS_CLK_IN);
    #1;
    cmp(64'(RDATA_OUT), 64'h0);
    cmp(64'(CFG_OUT), 64'h0);
    cmp(64'(CHK_VALID_OUT), 64'h0);
    @(posedge SYS_CLK_IN);
    RST_IN <= 1'b0;
    m_rd = 8'h00;
    m_frames = 5'h00;
    m_conv = 1'b0;
    m_cs = 2'h0;
    m_u1 = 8'h00;
    m_u2 = 8'h00;
  endtask

  task automatic close_out();
    $display("counts: checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Clock, watchdog and sequence
  initial begin
    SYS_CLK_IN = 1'b0;
    forever #25 SYS_CLK_IN = ~SYS_CLK_IN;
  end

  initial begin
    #1000000;
    n_fail++;
    close_out();
  end

  initial begin
    logic [31:0] rv;
    logic w;
    logic r;
    RST_IN = 1'b1;
    REQ_IN = '0;
    IDENT_IN = '0;
    n_fail = 0;
    checks = 0;
    void'($urandom(12));
    do_reset();
    for (int a = 8'h6e; a <= 8'h7b; a++) acc(8'(a), 8'h00, 1'b0, 1'b1);
    $display("test reset_values done");
    for (int a = 8'h70; a <= 8'h79; a++) acc(8'(a), 8'hff, 1'b1, 1'b0);
    for (int a = 8'h6e; a <= 8'h7b; a++) acc(8'(a), 8'h00, 1'b0, 1'b1);
    for (int i = 0; i < 4; i++) acc(8'h72, {2'(i), 6'h3f}, 1'b1, 1'b1);
    $display("test write_all_ones done");
    repeat (300) begin
      rv = $urandom;
      if (rv[2:0] == 3'h0) set_ident(rv[31:7]);
      rv = $urandom;
      w = rv[8];
      r = rv[9] | ~w;
      acc(8'h6c + 8'(rv[31:16] % 20), rv[7:0], w, r);
    end
    $display("test random_access done");
    acc(8'h76, 8'ha5, 1'b1, 1'b0);
    acc(8'h70, 8'h1f, 1'b1, 1'b0);
    do_reset();
    acc(8'h76, 8'h00, 1'b0, 1'b1);
    acc(8'h70, 8'h00, 1'b0, 1'b1);
    acc(8'h78, 8'h00, 1'b0, 1'b1);
    $display("test second_reset done");
    close_out();
  end
endmodule
